// >>> hdl/cdmon_monitor_pins.sv
`timescale 1ns/1ps
module cdmon_monitor_pins #(
	parameter int unsigned FRAME_HALF_CYCLES = cdmon_pkg::FRAME_HALF_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Asynchronous pins
	input wire logic system_reset_n_i,
	input wire logic dram_addr_bit11_in_i,
	input wire logic audio_serial_in_i,
	input wire logic word_clock_in_i,
	input wire logic bit_clock_in_i,
	// Command bits
	input wire logic monitor_main_select_i,
	input wire logic servo_serial_select_i,
	input wire logic monitor_set_sel_hi_i,
	input wire logic monitor_set_sel_lo_i,
	input wire logic double_speed_i,
	input wire logic cavw_mode_i,
	input wire logic vari_pitch_i,
	input wire logic [cdmon_pkg::PITCH_W-1:0] pitch_offset_i,
	input wire logic wp_input_select_i,
	input wire logic ext_audio_select_i,
	input wire logic dram_addr_bit11_i,
	// Internal status from the processor core
	input wire logic mirror_detect_i,
	input wire logic track_count_pulse_i,
	input wire logic subcode_frame_sync_i,
	input wire logic c2_error_flag_i,
	input wire logic [3:0] internal_monitor_i,
	input wire logic sync_protect_active_i,
	input wire logic frame_sync_detect_i,
	input wire logic sync_expected_i,
	input wire logic [cdmon_pkg::JIT_W-1:0] jitter_frame_offset_i,
	input wire logic subq_received_i,
	input wire logic efm_bit_clock_i,
	input wire logic servo_serial_data_i,
	input wire logic servo_serial_clock_i,
	input wire logic servo_serial_latch_n_i,
	// Audio sample stream
	input wire logic [cdmon_pkg::SAMPLE_W-1:0] sample_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	// Monitor pins
	output logic pin_count_o,
	output logic pin_error_o,
	output logic pin_sync_good_o,
	output logic pin_raw_sync_o,
	output logic pin_pll_clock_o,
	output logic mirror_detect_o,
	// Clock outputs
	output logic ref_clock_176k_o,
	output logic clock_8m_out_o,
	// Audio serial interface
	output logic word_clock_out_o,
	output logic bit_clock_out_o,
	output logic audio_serial_out_o,
	// Address bit 11 pin
	output logic dram_addr_bit11_out_o,
	output logic dram_addr_bit11_oe_o,
	output logic dram_write_prohibit_o
);
	// Pin synchronisers: first stage is read only by the second
	logic [4:0] sy1_r;
	logic [4:0] sy2_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sy1_r <= 5'h00;
			sy2_r <= 5'h00;
		end else begin
			sy1_r <= {system_reset_n_i, dram_addr_bit11_in_i,
				audio_serial_in_i, word_clock_in_i, bit_clock_in_i};
			sy2_r <= sy1_r;
		end
	end
	logic sys_rst_n;
	assign sys_rst_n = sy2_r[4];

	// Clock generators
	cdmon_nco_if ref_if();
	cdmon_nco_if bck_if();
	cdmon_nco_if c4m_if();
	cdmon_nco_if r8m_if();
	cdmon_nco_if crystal_two_thirds_clock_if();
	logic signed [cdmon_pkg::NCO_W-1:0] pitch_ext;
	assign pitch_ext = cdmon_pkg::NCO_W'($signed(pitch_offset_i));
	assign ref_if.run = sys_rst_n;
	assign ref_if.inc = double_speed_i ? cdmon_pkg::INC_REF_HALF
		: cdmon_pkg::INC_REF;
	assign bck_if.run = 1'b1;
	assign bck_if.inc = cdmon_pkg::INC_BCK;
	assign c4m_if.run = 1'b1;
	// Rate follows the disc in wide-range or pitch mode
	assign c4m_if.inc = (cavw_mode_i || vari_pitch_i)
		? cdmon_pkg::INC_C4M + pitch_ext
		: cdmon_pkg::INC_C4M;
	assign r8m_if.run = 1'b1;
	assign r8m_if.inc = cdmon_pkg::INC_R8M;
	assign crystal_two_thirds_clock_if.run = 1'b1;
	assign crystal_two_thirds_clock_if.inc = cdmon_pkg::INC_CRYSTAL_TWO_THIRDS_CLOCK;

	cdmon_nco u_ref (.clk_i(clk_i), .rst_i(rst_i), .nco(ref_if));
	cdmon_nco u_bck (.clk_i(clk_i), .rst_i(rst_i), .nco(bck_if));
	cdmon_nco u_c4m (.clk_i(clk_i), .rst_i(rst_i), .nco(c4m_if));
	cdmon_nco u_r8m (.clk_i(clk_i), .rst_i(rst_i), .nco(r8m_if));
	cdmon_nco u_crystal_two_thirds_clock (.clk_i(clk_i), .rst_i(rst_i), .nco(crystal_two_thirds_clock_if));

	// Crystal frame clock: fixed half-period counter, blind to disc speed
	logic [15:0] frm_cnt_r;
	logic [15:0] frm_cnt_nxt;
	logic frm_clk_r;
	logic frm_clk_nxt;
	always_comb begin
		frm_cnt_nxt = frm_cnt_r + 16'h0001;
		frm_clk_nxt = frm_clk_r;
		if (frm_cnt_r == 16'(FRAME_HALF_CYCLES - 1)) begin
			frm_cnt_nxt = 16'h0000;
			frm_clk_nxt = ~frm_clk_r;
		end
	end

	// Sync status flags
	logic raw_sync_n_r;
	logic raw_sync_n_nxt;
	logic sync_good_r;
	logic sync_good_nxt;
	logic win_rel_r;
	logic win_rel_nxt;
	logic jit_ovf_n_r;
	logic jit_ovf_n_nxt;
	logic pll_clk_n_r;
	logic pll_clk_n_nxt;
	logic signed [cdmon_pkg::JIT_W-1:0] jit;
	always_comb begin
		jit = $signed(jitter_frame_offset_i);
		raw_sync_n_nxt = ~frame_sync_detect_i;
		sync_good_nxt = sync_good_r;
		if (frame_sync_detect_i) begin
			sync_good_nxt = sync_expected_i;
		end
		win_rel_nxt = ~sync_protect_active_i;
		jit_ovf_n_nxt = ~((jit > cdmon_pkg::JIT_MARGIN)
			|| (jit < -cdmon_pkg::JIT_MARGIN));
		// Falling edge of this copy sits on the EFM transition
		pll_clk_n_nxt = ~efm_bit_clock_i;
	end

	// Latched selection; pins switch one edge later from registers
	logic [3:0] sel_r;
	logic [3:0] sel_nxt;
	assign sel_nxt = {monitor_main_select_i, servo_serial_select_i,
		monitor_set_sel_hi_i, monitor_set_sel_lo_i};

	// Monitor pin set, chosen from the latched selection
	logic [4:0] mon_nxt;
	always_comb begin
		mon_nxt = {track_count_pulse_i, c2_error_flag_i, sync_good_r,
			raw_sync_n_r, pll_clk_n_r};
		if (sel_r[3]) begin
			mon_nxt = {subcode_frame_sync_i, c2_error_flag_i, sync_good_r,
				subq_received_i, win_rel_r};
		end else if (sel_r[2]) begin
			mon_nxt = {track_count_pulse_i, c2_error_flag_i,
				servo_serial_latch_n_i, servo_serial_data_i,
				servo_serial_clock_i};
		end else begin
			case (sel_r[1:0])
			cdmon_pkg::SET_DEFAULT: begin
				mon_nxt = {track_count_pulse_i, c2_error_flag_i,
					sync_good_r, raw_sync_n_r, pll_clk_n_r};
			end
			cdmon_pkg::SET_MONITOR: begin
				mon_nxt = {track_count_pulse_i, internal_monitor_i[3],
					internal_monitor_i[2], internal_monitor_i[0],
					internal_monitor_i[1]};
			end
			cdmon_pkg::SET_XTAL: begin
				mon_nxt = {track_count_pulse_i, win_rel_r, jit_ovf_n_r,
					frm_clk_r, pll_clk_n_r};
			end
			cdmon_pkg::SET_CLOCKS: begin
				mon_nxt = {track_count_pulse_i, c2_error_flag_i,
					sync_good_r, c4m_if.lvl, crystal_two_thirds_clock_if.lvl};
			end
			default: begin
				mon_nxt = {track_count_pulse_i, c2_error_flag_i,
					sync_good_r, raw_sync_n_r, pll_clk_n_r};
			end
			endcase
		end
	end

	// Two-entry sample buffer so a late serializer loses no word
	logic [cdmon_pkg::SAMPLE_W-1:0] buf_r [2];
	logic [cdmon_pkg::SAMPLE_W-1:0] buf_nxt [2];
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic rd_r;
	logic rd_nxt;
	logic wr_r;
	logic wr_nxt;
	logic rdy_r;
	logic rdy_nxt;
	logic push;
	logic pop;

	// Serializer state
	logic [cdmon_pkg::SHIFT_W-1:0] sh_r;
	logic [cdmon_pkg::SHIFT_W-1:0] sh_nxt;
	logic [cdmon_pkg::BITCNT_W-1:0] bit_r;
	logic [cdmon_pkg::BITCNT_W-1:0] bit_nxt;
	logic bck_d_r;
	logic bck_fall;
	logic [cdmon_pkg::SAMPLE_W-1:0] head;

	assign bck_fall = bck_d_r && !bck_if.lvl;
	assign head = buf_r[rd_r];
	assign push = sample_valid_i && rdy_r;
	// A word is drawn at the start of each stereo frame while the buffer holds one
	assign pop = bck_fall && (bit_r == '0) && (cnt_r != 2'h0);

	always_comb begin
		buf_nxt = buf_r;
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		if (push) begin
			buf_nxt[wr_r] = sample_i;
			wr_nxt = ~wr_r;
		end
		if (pop) begin
			rd_nxt = ~rd_r;
		end
		cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
		// Back-pressure reaches the source when both entries hold
		rdy_nxt = (cnt_nxt != cdmon_pkg::BUF_DEPTH);
	end

	// Shift out MSB first; each channel 16 data bits then zero pad
	always_comb begin
		sh_nxt = sh_r;
		bit_nxt = bit_r;
		if (bck_fall) begin
			bit_nxt = bit_r + 6'h01;
			if (bit_r == '0) begin
				sh_nxt = '0;
				if (cnt_r != 2'h0) begin
					sh_nxt = {head[cdmon_pkg::SAMPLE_W-1 -: cdmon_pkg::CHAN_W],
						16'h0000, head[cdmon_pkg::CHAN_W-1:0],
						16'h0000};
				end
			end else begin
				sh_nxt = {sh_r[cdmon_pkg::SHIFT_W-2:0], 1'b0};
			end
		end
	end

	// Output selection for the audio interface
	logic wck_nxt;
	logic bck_nxt;
	logic sdo_nxt;
	always_comb begin
		// Word clock: high for left half, one period per stereo frame
		wck_nxt = ~bit_r[cdmon_pkg::BITCNT_W-1];
		bck_nxt = bck_if.lvl;
		sdo_nxt = sh_r[cdmon_pkg::SHIFT_W-1];
		if (ext_audio_select_i) begin
			// External source already in the same bit order
			wck_nxt = sy2_r[1];
			bck_nxt = sy2_r[0];
			sdo_nxt = sy2_r[2];
		end
	end

	// Registers for the frame clock, sync flag, selection, buffer and serializer groups
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frm_cnt_r <= 16'h0000;
			frm_clk_r <= 1'b0;
			raw_sync_n_r <= 1'b1;
			sync_good_r <= 1'b0;
			win_rel_r <= 1'b0;
			jit_ovf_n_r <= 1'b1;
			pll_clk_n_r <= 1'b1;
			sel_r <= 4'h0;
			buf_r[0] <= '0;
			buf_r[1] <= '0;
			cnt_r <= 2'h0;
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			rdy_r <= 1'b0;
			sh_r <= '0;
			bit_r <= '0;
			bck_d_r <= 1'b0;
		end else begin
			frm_cnt_r <= frm_cnt_nxt;
			frm_clk_r <= frm_clk_nxt;
			raw_sync_n_r <= raw_sync_n_nxt;
			sync_good_r <= sync_good_nxt;
			win_rel_r <= win_rel_nxt;
			jit_ovf_n_r <= jit_ovf_n_nxt;
			pll_clk_n_r <= pll_clk_n_nxt;
			sel_r <= sel_nxt;
			buf_r <= buf_nxt;
			cnt_r <= cnt_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			rdy_r <= rdy_nxt;
			sh_r <= sh_nxt;
			bit_r <= bit_nxt;
			bck_d_r <= bck_if.lvl;
		end
	end

	// Output registers: every pin comes straight from a flip-flop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{pin_count_o, pin_error_o, pin_sync_good_o} <= 3'h0;
			pin_raw_sync_o <= 1'b1;
			pin_pll_clock_o <= 1'b1;
			mirror_detect_o <= 1'b0;
			ref_clock_176k_o <= 1'b0;
			clock_8m_out_o <= 1'b0;
			word_clock_out_o <= 1'b0;
			bit_clock_out_o <= 1'b0;
			audio_serial_out_o <= 1'b0;
			dram_addr_bit11_out_o <= 1'b0;
			dram_addr_bit11_oe_o <= 1'b1;
			dram_write_prohibit_o <= 1'b0;
		end else begin
			{pin_count_o, pin_error_o, pin_sync_good_o, pin_raw_sync_o,
				pin_pll_clock_o} <= mon_nxt;
			mirror_detect_o <= mirror_detect_i;
			ref_clock_176k_o <= ref_if.lvl && sys_rst_n;
			clock_8m_out_o <= r8m_if.lvl;
			word_clock_out_o <= wck_nxt;
			bit_clock_out_o <= bck_nxt;
			audio_serial_out_o <= sdo_nxt;
			dram_addr_bit11_out_o <= dram_addr_bit11_i;
			// Pin turns to input; the far end drives write-prohibit
			dram_addr_bit11_oe_o <= ~wp_input_select_i;
			dram_write_prohibit_o <= wp_input_select_i && sy2_r[3];
		end
	end

	assign sample_ready_o = rdy_r;
endmodule

// >>> hdl/cdmon_nco.sv
`timescale 1ns/1ps
// Phase accumulator; the output toggles on each carry, so the
// average rate is exact while single periods jitter by one cycle
module cdmon_nco (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Generator port
	cdmon_nco_if.gen nco
);
	logic [cdmon_pkg::NCO_W-1:0] acc_r;
	logic [cdmon_pkg::NCO_W-1:0] acc_nxt;
	logic lvl_r;
	logic lvl_nxt;
	logic [cdmon_pkg::NCO_W:0] sum;

	// Next phase; a stopped generator rests low
	always_comb begin
		sum = {1'b0, acc_r} + {1'b0, nco.inc};
		acc_nxt = sum[cdmon_pkg::NCO_W-1:0];
		lvl_nxt = lvl_r ^ sum[cdmon_pkg::NCO_W];
		if (!nco.run) begin
			acc_nxt = '0;
			lvl_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_r <= '0;
			lvl_r <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			lvl_r <= lvl_nxt;
		end
	end

	assign nco.lvl = lvl_r;
endmodule

// >>> hdl/cdmon_nco_if.sv
`timescale 1ns/1ps
// Control and result of one square-wave generator
interface cdmon_nco_if;
	logic run;
	logic [cdmon_pkg::NCO_W-1:0] inc;
	logic lvl;
	modport gen (input run, input inc, output lvl);
	modport user (output run, output inc, input lvl);
endinterface

// >>> hdl/cdmon_pkg.sv
package cdmon_pkg;
	// Master clock
	localparam longint CLK_HZ = 200000000;
	localparam int CLK_PERIOD_PS = 5000;

	// Crystal and derived clock rates, in Hz
	localparam longint XTAL_HZ = 16934400;
	localparam longint REF_HZ = 176400;
	localparam longint FS_HZ = 44100;
	localparam longint BITS_PER_FRAME = 64;
	localparam longint BCK_HZ = FS_HZ * BITS_PER_FRAME;
	localparam longint C4M_HZ = 4233600;
	localparam longint R8M_HZ = 8467200;
	localparam longint TWO_THIRDS_NUM = 2;
	localparam longint TWO_THIRDS_DEN = 3;
	localparam longint CRYSTAL_TWO_THIRDS_CLOCK_HZ = XTAL_HZ * TWO_THIRDS_NUM / TWO_THIRDS_DEN;

	// Crystal frame clock period and its half period in master cycles
	localparam int FRAME_PERIOD_NS = 136000;
	localparam int FRAME_HALF_CYCLES =
		FRAME_PERIOD_NS * 1000 / CLK_PERIOD_PS / 2;

	// Phase accumulator step for a square wave of the given frequency
	localparam int NCO_W = 32;
	function automatic logic [NCO_W-1:0] nco_inc(input longint hz);
		return NCO_W'((hz * 2 * 64'h0000_0001_0000_0000) / CLK_HZ);
	endfunction

	localparam logic [NCO_W-1:0] INC_REF = nco_inc(REF_HZ);
	localparam logic [NCO_W-1:0] INC_REF_HALF = nco_inc(REF_HZ / 2);
	localparam logic [NCO_W-1:0] INC_BCK = nco_inc(BCK_HZ);
	localparam logic [NCO_W-1:0] INC_C4M = nco_inc(C4M_HZ);
	localparam logic [NCO_W-1:0] INC_R8M = nco_inc(R8M_HZ);
	localparam logic [NCO_W-1:0] INC_CRYSTAL_TWO_THIRDS_CLOCK = nco_inc(CRYSTAL_TWO_THIRDS_CLOCK_HZ);

	// Jitter buffer margin in frames
	localparam int JIT_W = 8;
	localparam logic signed [JIT_W-1:0] JIT_MARGIN = 8'sh1c;

	// Monitor set codes, high bit then low bit
	localparam logic [1:0] SET_DEFAULT = 2'h0;
	localparam logic [1:0] SET_MONITOR = 2'h1;
	localparam logic [1:0] SET_XTAL = 2'h2;
	localparam logic [1:0] SET_CLOCKS = 2'h3;

	// Audio sample: left in high half, right in low half
	localparam int SAMPLE_W = 32;
	localparam int CHAN_W = 16;
	localparam int SHIFT_W = 64;
	localparam int BITCNT_W = 6;
	localparam int PITCH_W = 16;
	localparam logic [1:0] BUF_DEPTH = 2'h2;
endpackage

// >>> testbench/cdmon_chk.sv
`timescale 1ns/1ps
// Ties each monitor pin to its selected source with the handed-over latency
module cdmon_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Command and pin inputs
	input wire logic system_reset_n_i,
	input wire logic monitor_main_select_i,
	input wire logic servo_serial_select_i,
	input wire logic monitor_set_sel_hi_i,
	input wire logic monitor_set_sel_lo_i,
	input wire logic wp_input_select_i,
	input wire logic ext_audio_select_i,
	input wire logic dram_addr_bit11_i,
	// External audio pins
	input wire logic audio_serial_in_i,
	input wire logic word_clock_in_i,
	// Core status
	input wire logic track_count_pulse_i,
	input wire logic subcode_frame_sync_i,
	input wire logic c2_error_flag_i,
	input wire logic [3:0] internal_monitor_i,
	input wire logic sync_protect_active_i,
	input wire logic frame_sync_detect_i,
	input wire logic sync_expected_i,
	input wire logic [cdmon_pkg::JIT_W-1:0] jitter_frame_offset_i,
	input wire logic efm_bit_clock_i,
	input wire logic servo_serial_data_i,
	input wire logic mirror_detect_i,
	// Watched outputs
	input wire logic pin_count_o,
	input wire logic pin_error_o,
	input wire logic pin_sync_good_o,
	input wire logic pin_raw_sync_o,
	input wire logic pin_pll_clock_o,
	input wire logic ref_clock_176k_o,
	input wire logic mirror_detect_o,
	input wire logic word_clock_out_o,
	input wire logic audio_serial_out_o,
	input wire logic dram_addr_bit11_out_o,
	input wire logic dram_addr_bit11_oe_o
);
	logic [1:0] up_r;
	logic [1:0] up_nxt;
	logic [3:0] sel;
	logic ok;
	// Edges since reset; history older than that is not trusted
	always_comb begin
		up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
	end
	always_ff @(posedge clk_i) begin
		up_r <= rst_i ? 2'h0 : up_nxt;
	end
	assign ok = (up_r == 2'h3);
	assign sel = {monitor_main_select_i, servo_serial_select_i,
		monitor_set_sel_hi_i, monitor_set_sel_lo_i};
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Multi-step behaviours
	sequence pin_reset_held;
		!system_reset_n_i [*4];
	endsequence
	sequence sync_in_default;
		frame_sync_detect_i && sel == 4'h0;
	endsequence
	count_pin_a: assert property (
		ok |-> pin_count_o == ($past(sel[3], 2) ?
		$past(subcode_frame_sync_i) : $past(track_count_pulse_i)))
		else $error("count pin source wrong");
	error_pin_a: assert property (
		ok |-> pin_error_o == ($past(sel, 2) == 4'h1 ?
		$past(internal_monitor_i[3]) : $past(sel, 2) == 4'h2 ?
		!$past(sync_protect_active_i, 2) : $past(c2_error_flag_i)))
		else $error("error pin source wrong");
	raw_sync_a: assert property (
		ok && $past(sel, 2) == 4'h0 |->
		pin_raw_sync_o == !$past(frame_sync_detect_i, 2))
		else $error("raw sync pin wrong");
	pll_invert_a: assert property (
		ok && $past(sel, 2) == 4'h0 |->
		pin_pll_clock_o == !$past(efm_bit_clock_i, 2))
		else $error("pll pin not inverted clock");
	window_pin_a: assert property (
		ok && $past(sel[3], 2) |->
		pin_pll_clock_o == !$past(sync_protect_active_i, 2))
		else $error("window status pin wrong");
	good_flag_a: assert property (
		sync_in_default |-> ##2 pin_sync_good_o == $past(sync_expected_i, 2))
		else $error("sync good flag wrong");
	overflow_flag_a: assert property (
		ok && $past(sel, 2) == 4'h2 |-> pin_sync_good_o ==
		!($signed($past(jitter_frame_offset_i, 2)) > 28 ||
		$signed($past(jitter_frame_offset_i, 2)) < -28))
		else $error("overflow flag wrong");
	servo_data_a: assert property (
		ok && $past(sel, 2) == 4'h4 |->
		pin_raw_sync_o == $past(servo_serial_data_i))
		else $error("servo data pin wrong");
	wp_enable_a: assert property (
		ok |-> dram_addr_bit11_oe_o == !$past(wp_input_select_i))
		else $error("address pin enable wrong");
	ref_low_a: assert property (
		pin_reset_held |=> !ref_clock_176k_o)
		else $error("ref clock not low in reset");
	mirror_pass_a: assert property (
		ok |-> mirror_detect_o == $past(mirror_detect_i))
		else $error("mirror pin wrong");
	addr_bit_a: assert property (
		ok |-> dram_addr_bit11_out_o == $past(dram_addr_bit11_i))
		else $error("address bit pin wrong");
	// Two synchroniser stages plus the output register
	ext_audio_a: assert property (
		ok && $past(ext_audio_select_i) |->
		audio_serial_out_o == $past(audio_serial_in_i, 3) &&
		word_clock_out_o == $past(word_clock_in_i, 3))
		else $error("external audio not passed through");
endmodule

// >>> testbench/cdmon_host_model.sv
`timescale 1ns/1ps
// Board side: resolves the address-11 wire and feeds external audio
module cdmon_host_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Address-11 pin
	input wire logic a11_out_i,
	input wire logic a11_oe_i,
	input wire logic wp_level_i,
	output logic a11_wire_o,
	// External audio source
	output logic word_clock_o,
	output logic bit_clock_o,
	output logic audio_serial_o
);
	localparam logic [31:0] EXT_WORD = 32'h8001_7ffe;
	logic [8:0] cnt_r = 9'h0;
	// Slot counter; eight cycles per bit, sixty-four slots per frame
	always_ff @(posedge clk_i) begin
		cnt_r <= rst_i ? 9'h0 : cnt_r + 9'h1;
	end
	// Whoever enables drives; with the pin released the board drives it
	assign a11_wire_o = a11_oe_i ? a11_out_i : wp_level_i;
	assign bit_clock_o = cnt_r[2];
	assign word_clock_o = !cnt_r[8];
	// Left then right, MSB first, low half of each channel zero
	assign audio_serial_o = !cnt_r[7] &&
		EXT_WORD[{!cnt_r[8], ~cnt_r[6:3]}];
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
// Random status, timed clock windows and an audio stream with a scoreboard
module testbench;
	localparam int W = 11340;
	localparam int HALF = 8;
	logic clk_i = 1'b0, rst_i = 1'b1, system_reset_n_i = 1'b1;
	logic dram_addr_bit11_in_i, audio_serial_in_i, word_clock_in_i;
	logic bit_clock_in_i, wp_level = 1'b0, double_speed_i = 1'b0;
	logic monitor_main_select_i, servo_serial_select_i;
	logic monitor_set_sel_hi_i, monitor_set_sel_lo_i;
	logic [3:0] sel_v = 4'h0;
	logic cavw_mode_i = 1'b0, vari_pitch_i = 1'b0;
	logic [cdmon_pkg::PITCH_W-1:0] pitch_offset_i = 16'h0;
	logic wp_input_select_i = 1'b0, ext_audio_select_i = 1'b0;
	logic dram_addr_bit11_i = 1'b0, mirror_detect_i = 1'b0;
	logic track_count_pulse_i = 1'b0, subcode_frame_sync_i = 1'b0;
	logic c2_error_flag_i = 1'b0, sync_protect_active_i = 1'b0;
	logic [3:0] internal_monitor_i = 4'h0;
	logic frame_sync_detect_i = 1'b0, sync_expected_i = 1'b0;
	logic [cdmon_pkg::JIT_W-1:0] jitter_frame_offset_i = 8'h0;
	logic subq_received_i = 1'b0, efm_bit_clock_i = 1'b0;
	logic servo_serial_data_i = 1'b0, servo_serial_clock_i = 1'b0;
	logic servo_serial_latch_n_i = 1'b1, sample_valid_i = 1'b0;
	logic [cdmon_pkg::SAMPLE_W-1:0] sample_i = 32'h0;
	logic sample_ready_o, pin_count_o, pin_error_o, pin_sync_good_o;
	logic pin_raw_sync_o, pin_pll_clock_o, mirror_detect_o;
	logic ref_clock_176k_o, clock_8m_out_o, word_clock_out_o;
	logic bit_clock_out_o, audio_serial_out_o, dram_addr_bit11_out_o;
	logic dram_addr_bit11_oe_o, dram_write_prohibit_o;
	int seed = 90972;
	int err_count = 0, check_count = 0, cyc = 0, nb = 0;
	int n [4];
	logic [63:0] exp_q [$];
	logic [63:0] sh = 64'h0;
	logic bck_q = 1'b0, wck_q = 1'b0, started = 1'b0, pend = 1'b0;
	logic got = 1'b0;
	logic [7:0] edge_tab [6] = '{8'h1c, 8'h1d, 8'he4, 8'he3, 8'h00, 8'h7f};
	logic [3:0] sets [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};

	assign {monitor_main_select_i, servo_serial_select_i,
		monitor_set_sel_hi_i, monitor_set_sel_lo_i} = sel_v;

	cdmon_monitor_pins #(.FRAME_HALF_CYCLES(HALF)) dut (.*);
	cdmon_host_model host (.clk_i(clk_i), .rst_i(rst_i),
		.a11_out_i(dram_addr_bit11_out_o), .a11_oe_i(dram_addr_bit11_oe_o),
		.wp_level_i(wp_level), .a11_wire_o(dram_addr_bit11_in_i),
		.word_clock_o(word_clock_in_i), .bit_clock_o(bit_clock_in_i),
		.audio_serial_o(audio_serial_in_i));

	always #2.5 clk_i = ~clk_i;

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask

	function automatic int expn(input longint hz);
		return int'(longint'(W) * cdmon_pkg::CLK_PERIOD_PS * hz /
			64'h0000_00e8_d4a5_1000);
	endfunction

	function automatic logic near(input int got, input int e);
		return got >= e - 1 && got <= e + 1;
	endfunction

	// Counts rising edges of four clock-like outputs over one window
	task automatic measure();
		logic [3:0] p;
		logic [3:0] c;
		tick(4);
		n = '{0, 0, 0, 0};
		p = {pin_pll_clock_o, pin_raw_sync_o, clock_8m_out_o, ref_clock_176k_o};
		for (int k = 0; k < W; k++) begin
			tick(1);
			c = {pin_pll_clock_o, pin_raw_sync_o, clock_8m_out_o,
				ref_clock_176k_o};
			for (int j = 0; j < 4; j++) n[j] += (c[j] && !p[j]);
			p = c;
		end
	endtask

	// Sends stereo words; the fourth must wait because the buffer is full
	task automatic feed();
		logic [31:0] w;
		int t;
		for (int i = 0; i < 6; i++) begin
			w = $random(seed);
			w = w | 32'h0001_0001;
			sample_i = w;
			sample_valid_i = 1'b1;
			t = 0;
			do begin
				@(posedge clk_i);
				t++;
			end while (sample_ready_o !== 1'b1 && t < 9000);
			exp_q.push_back({w[31:16], 16'h0, w[15:0], 16'h0});
			if (i == 3) check(t > 20, 1'b1);
			check(t < 9000, 1'b1);
			#1;
		end
		sample_valid_i = 1'b0;
	endtask

	// Core status changes at random every cycle
	always @(posedge clk_i) begin
		#1;
		{mirror_detect_i, track_count_pulse_i, subcode_frame_sync_i,
			c2_error_flag_i, internal_monitor_i, sync_protect_active_i,
			sync_expected_i, subq_received_i, efm_bit_clock_i} = 12'($random(seed));
		{servo_serial_data_i, servo_serial_clock_i, servo_serial_latch_n_i,
			cavw_mode_i, vari_pitch_i, dram_addr_bit11_i} = 6'($random(seed));
		frame_sync_detect_i = !frame_sync_detect_i && ($random(seed) & 3) == 0;
		jitter_frame_offset_i = edge_tab[$unsigned($random(seed)) % 6];
		pitch_offset_i = 16'($random(seed) % 8);
	end

	// Rebuilds each stereo frame and takes the oldest note to compare;
	// the word clock leads the data by one bit, so a frame closes on
	// the first bit after the word clock rises
	always @(negedge clk_i) begin
		got = !bck_q && bit_clock_out_o === 1'b1 && !ext_audio_select_i;
		if (got) begin
			sh = {sh[62:0], audio_serial_out_o};
			nb++;
		end
		if (got && pend) begin
			if (started) check(nb, 64);
			if (sh !== 64'h0)
				check(sh, exp_q.size() > 0 ? exp_q.pop_front() : 64'h0);
			nb = 0;
			started = 1'b1;
			pend = 1'b0;
		end
		if (!wck_q && word_clock_out_o === 1'b1) pend = 1'b1;
		bck_q = bit_clock_out_o;
		wck_q = word_clock_out_o;
	end

	// A hang counts as a mismatch
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 100000) begin
			err_count++;
			results();
		end
	end

	initial begin
		tick(11);
		check(pin_raw_sync_o, 1'b1);
		check(pin_pll_clock_o, 1'b1);
		check(dram_addr_bit11_oe_o, 1'b1);
		tick(1);
		rst_i = 1'b0;
		tick(1);
		fork
			feed();
			begin
				foreach (sets[i]) begin
					sel_v = sets[i];
					tick(60);
				end
				sel_v = 4'h3;
				measure();
				check(near(n[0], expn(cdmon_pkg::REF_HZ)), 1'b1);
				check(near(n[1], expn(cdmon_pkg::R8M_HZ)), 1'b1);
				check(near(n[2], expn(cdmon_pkg::C4M_HZ)), 1'b1);
				check(near(n[3], expn(cdmon_pkg::CRYSTAL_TWO_THIRDS_CLOCK_HZ)), 1'b1);
				sel_v = 4'h2;
				measure();
				check(near(n[2], W / (2 * HALF)), 1'b1);
				double_speed_i = 1'b1;
				measure();
				check(near(n[0], expn(cdmon_pkg::REF_HZ / 2)), 1'b1);
				double_speed_i = 1'b0;
				system_reset_n_i = 1'b0;
				tick(8);
				check(ref_clock_176k_o, 1'b0);
				system_reset_n_i = 1'b1;
				wp_input_select_i = 1'b1;
				for (int k = 0; k < 2; k++) begin
					wp_level = 1'(k);
					tick(6);
					check(dram_write_prohibit_o, wp_level);
					check(dram_addr_bit11_oe_o, 1'b0);
				end
				wp_input_select_i = 1'b0;
			end
		join
		for (int k = 0; k < 20000 && exp_q.size() > 0; k++) tick(1);
		check(exp_q.size(), 0);
		// External source on the audio pins; the checker follows it
		ext_audio_select_i = 1'b1;
		tick(1200);
		results();
	end
endmodule

bind cdmon_monitor_pins cdmon_chk u_chk (.*);
